// ---- logic/rlp_pkg.sv ----
// Package for the relay logic primitives: widths, gate modes, carrier structs
package rlp_pkg;

    localparam int CMP_W = 16;
    localparam int TMR_W = 16;

    localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;

    typedef enum logic [2:0] {
        GATE_OR,
        GATE_XOR,
        GATE_NOR,
        GATE_AND,
        GATE_AND_INV,
        GATE_NAND
    } rlp_gate_mode_t;

    // Per-gate configuration: function plus independent inverters
    typedef struct packed {
        rlp_gate_mode_t mode;
        logic inv_a;
        logic inv_b;
        logic inv_out;
    } rlp_gate_cfg_t;

    typedef struct packed {
        logic [TMR_W-1:0] pickup;
        logic [TMR_W-1:0] dropout;
    } rlp_delay_cfg_t;

    typedef struct packed {
        logic [TMR_W-1:0] delay;
        logic [TMR_W-1:0] pulse;
    } rlp_edge_cfg_t;

    typedef struct packed {
        logic set;
        logic clr;
    } rlp_latch_in_t;

endpackage

// ---- logic/rlp_primitives.sv ----
// Relay logic primitives evaluated once per processing interval
`timescale 1ns/1ns

module rlp_primitives #(
    parameter int CMP_W = rlp_pkg::CMP_W,
    parameter int TMR_W = rlp_pkg::TMR_W
) (
    input wire logic sys_clk, // 125 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic tick, // One-cycle pulse per processing interval
    input wire logic [CMP_W-1:0] cmp_a, // Comparator operand A
    input wire logic [CMP_W-1:0] cmp_b, // Comparator operand B
    output logic cmp_out, // A greater than B
    input wire rlp_pkg::rlp_gate_cfg_t gate_cfg, // Gate function and inverters
    input wire logic gate_a, // Gate input A
    input wire logic gate_b, // Gate input B
    output logic gate_out, // Gate result
    input wire rlp_pkg::rlp_delay_cfg_t dly_cfg, // Pickup and dropout in intervals
    input wire logic dly_in, // Delay timer input
    output logic dly_out, // Delay timer output
    input wire rlp_pkg::rlp_edge_cfg_t edge_cfg, // Delay and pulse in intervals
    input wire logic edge_in, // Edge timer input
    output logic edge_out, // Edge timer output
    output logic edge_busy, // Edge timer running, input ignored
    input wire rlp_pkg::rlp_latch_in_t latch_in, // Set and reset
    output logic latch_out, // Latch state
    input wire logic fall_in, // Falling-edge detector input
    output logic fall_out // One-interval pulse on falling edge
);

    // ==========================================================
    // Combinational next values, registered on each tick
    // ==========================================================
    function automatic logic gate_eval(input rlp_pkg::rlp_gate_cfg_t cfg,
                                       input logic a_raw, input logic b_raw);
        logic a;
        logic b;
        logic r;
        a = a_raw ^ cfg.inv_a;
        b = b_raw ^ cfg.inv_b;
        case (cfg.mode)
            rlp_pkg::GATE_OR: r = a | b;
            rlp_pkg::GATE_XOR: r = a ^ b;
            rlp_pkg::GATE_NOR: r = ~(a | b);
            rlp_pkg::GATE_AND: r = a & b;
            rlp_pkg::GATE_AND_INV: r = a & ~b;
            rlp_pkg::GATE_NAND: r = ~(a & b);
            default: r = 1'b0;
        endcase
        return r ^ cfg.inv_out;
    endfunction

    logic cmp_next;
    logic gate_next;
    assign cmp_next = cmp_a > cmp_b;
    assign gate_next = gate_eval(gate_cfg, gate_a, gate_b);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmp_out <= 1'b0;
            gate_out <= 1'b0;
        end else if (tick) begin
            cmp_out <= cmp_next;
            gate_out <= gate_next;
        end
    end

    // ==========================================================
    // Pickup / dropout delay timer
    // ==========================================================
    // Counts intervals the input has held its new level; output
    // follows the input once the count reaches pickup or exceeds dropout.
    logic [TMR_W-1:0] dly_cnt_reg;
    logic [TMR_W-1:0] dly_cnt_next;
    logic dly_out_next;

    always_comb begin
        dly_cnt_next = rlp_pkg::TMR_ZERO;
        dly_out_next = dly_out;
        if (dly_in && !dly_out) begin
            dly_cnt_next = dly_cnt_reg + rlp_pkg::TMR_ONE;
            if (dly_cnt_next >= dly_cfg.pickup || dly_cfg.pickup == rlp_pkg::TMR_ZERO) begin
                dly_out_next = 1'b1;
                dly_cnt_next = rlp_pkg::TMR_ZERO;
            end
        end else if (!dly_in && dly_out) begin
            dly_cnt_next = dly_cnt_reg + rlp_pkg::TMR_ONE;
            if (dly_cnt_next > dly_cfg.dropout || dly_cfg.dropout == rlp_pkg::TMR_ZERO) begin
                dly_out_next = 1'b0;
                dly_cnt_next = rlp_pkg::TMR_ZERO;
            end
        end
        // Any break in the input returns the count to zero
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dly_cnt_reg <= rlp_pkg::TMR_ZERO;
            dly_out <= 1'b0;
        end else if (tick) begin
            dly_cnt_reg <= dly_cnt_next;
            dly_out <= dly_out_next;
        end
    end

    // ==========================================================
    // Edge-triggered timer with lockout
    // ==========================================================
    typedef enum logic [1:0] {
        EDGE_IDLE,
        EDGE_DELAY,
        EDGE_PULSE
    } rlp_edge_state_t;

    rlp_edge_state_t edge_state_reg;
    logic [TMR_W-1:0] edge_cnt_reg;
    logic edge_prev_reg;
    logic edge_rise;

    // The previous level is tracked on every tick, busy or not, so an input
    // held high through a run does not count as a new rise afterwards.
    assign edge_rise = edge_in && !edge_prev_reg;
    assign edge_busy = edge_state_reg != EDGE_IDLE;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_state_reg <= EDGE_IDLE;
            edge_cnt_reg <= rlp_pkg::TMR_ZERO;
            edge_out <= 1'b0;
            edge_prev_reg <= 1'b0;
        end else if (tick) begin
            edge_prev_reg <= edge_in;
            case (edge_state_reg)
                EDGE_IDLE: begin
                    if (edge_rise) begin
                        if (edge_cfg.delay == rlp_pkg::TMR_ZERO) begin
                            edge_state_reg <= EDGE_PULSE;
                            edge_out <= 1'b1;
                        end else begin
                            edge_state_reg <= EDGE_DELAY;
                        end
                        edge_cnt_reg <= rlp_pkg::TMR_ONE;
                    end
                end
                EDGE_DELAY: begin
                    if (edge_cnt_reg >= edge_cfg.delay) begin
                        edge_state_reg <= EDGE_PULSE;
                        edge_out <= 1'b1;
                        edge_cnt_reg <= rlp_pkg::TMR_ONE;
                    end else begin
                        edge_cnt_reg <= edge_cnt_reg + rlp_pkg::TMR_ONE;
                    end
                end
                EDGE_PULSE: begin
                    if (edge_cnt_reg >= edge_cfg.pulse) begin
                        edge_state_reg <= EDGE_IDLE;
                        edge_out <= 1'b0;
                        edge_cnt_reg <= rlp_pkg::TMR_ZERO;
                    end else begin
                        edge_cnt_reg <= edge_cnt_reg + rlp_pkg::TMR_ONE;
                    end
                end
                default: begin
                    edge_state_reg <= EDGE_IDLE;
                    edge_out <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Set/reset latch and falling-edge detector
    // ==========================================================
    logic fall_prev_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latch_out <= 1'b0;
        end else if (tick) begin
            if (latch_in.clr) begin
                latch_out <= 1'b0;
            end else if (latch_in.set) begin
                latch_out <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fall_prev_reg <= 1'b0;
            fall_out <= 1'b0;
        end else if (tick) begin
            fall_prev_reg <= fall_in;
            fall_out <= fall_prev_reg && !fall_in;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    // Typed gate settings, so that the comparisons below have a defined width
    localparam rlp_pkg::rlp_gate_cfg_t CFG_OR = '{rlp_pkg::GATE_OR, 1'b0, 1'b0, 1'b0};
    localparam rlp_pkg::rlp_gate_cfg_t CFG_XOR = '{rlp_pkg::GATE_XOR, 1'b0, 1'b0, 1'b0};
    localparam rlp_pkg::rlp_gate_cfg_t CFG_NOR = '{rlp_pkg::GATE_NOR, 1'b0, 1'b0, 1'b0};
    localparam rlp_pkg::rlp_gate_cfg_t CFG_AND = '{rlp_pkg::GATE_AND, 1'b0, 1'b0, 1'b0};
    localparam rlp_pkg::rlp_gate_cfg_t CFG_AND_INV = '{rlp_pkg::GATE_AND_INV, 1'b0, 1'b0, 1'b0};
    localparam rlp_pkg::rlp_gate_cfg_t CFG_NAND = '{rlp_pkg::GATE_NAND, 1'b0, 1'b0, 1'b0};
    localparam rlp_pkg::rlp_gate_cfg_t CFG_XOR_INV = '{rlp_pkg::GATE_XOR, 1'b1, 1'b0, 1'b1};

    // Edge timer steps; ticks may be far apart, so each check covers one step
    sequence s_edge_fire;
        tick && !edge_busy && edge_in && !edge_prev_reg && edge_cfg.delay == rlp_pkg::TMR_ZERO;
    endsequence

    sequence s_edge_due;
        tick && edge_state_reg == EDGE_DELAY && edge_cnt_reg >= edge_cfg.delay;
    endsequence

    sequence s_pulse_hold;
        tick && edge_out && edge_cnt_reg < edge_cfg.pulse;
    endsequence

    sequence s_pulse_last;
        tick && edge_out && edge_cnt_reg >= edge_cfg.pulse;
    endsequence

    sequence s_zero_pulse_end;
        tick && edge_out && edge_cfg.pulse == rlp_pkg::TMR_ZERO;
    endsequence

    chk_cmp_strict: assert property (@(posedge sys_clk) disable iff (rst)
        tick |=> cmp_out == $past(cmp_a > cmp_b))
        else $error("comparator output wrong");

    chk_gate_or: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_OR |=> gate_out == ($past(gate_a) || $past(gate_b)))
        else $error("or gate output wrong");

    chk_gate_xor: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_XOR |=> gate_out == ($past(gate_a) != $past(gate_b)))
        else $error("xor gate output wrong");

    chk_gate_nor: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_NOR |=> gate_out == !($past(gate_a) || $past(gate_b)))
        else $error("nor gate output wrong");

    chk_gate_and: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_AND |=> gate_out == ($past(gate_a) && $past(gate_b)))
        else $error("and gate output wrong");

    chk_gate_and_inv: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_AND_INV |=> gate_out == ($past(gate_a) && !$past(gate_b)))
        else $error("and with inverted input wrong");

    chk_gate_nand: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_NAND && !gate_a |=> gate_out)
        else $error("nand gate output wrong");

    chk_gate_xor_inv: assert property (@(posedge sys_clk) disable iff (rst)
        tick && gate_cfg == CFG_XOR_INV |=> gate_out == ($past(gate_a) ~^ ~$past(gate_b)))
        else $error("inverted xor output wrong");

    chk_dly_zero_pick: assert property (@(posedge sys_clk) disable iff (rst)
        tick && dly_in && dly_cfg.pickup == rlp_pkg::TMR_ZERO |=> dly_out)
        else $error("zero pickup not immediate");

    chk_dly_zero_drop: assert property (@(posedge sys_clk) disable iff (rst)
        tick && !dly_in && dly_cfg.dropout == rlp_pkg::TMR_ZERO |=> !dly_out)
        else $error("zero dropout not immediate");

    chk_dly_no_early: assert property (@(posedge sys_clk) disable iff (rst)
        tick && !dly_out && !dly_in |=> !dly_out)
        else $error("delay output rose without input");

    chk_dly_pick_wait: assert property (@(posedge sys_clk) disable iff (rst)
        tick && dly_in && !dly_out && dly_cfg.pickup != rlp_pkg::TMR_ZERO
        && dly_cnt_reg < dly_cfg.pickup - rlp_pkg::TMR_ONE |=> !dly_out)
        else $error("delay output rose before pickup time");

    chk_dly_drop_hold: assert property (@(posedge sys_clk) disable iff (rst)
        tick && !dly_in && dly_out && dly_cnt_reg < dly_cfg.dropout |=> dly_out)
        else $error("delay output fell before dropout time");

    chk_edge_zero_fire: assert property (@(posedge sys_clk) disable iff (rst)
        s_edge_fire |=> edge_out && edge_busy)
        else $error("edge timer missed zero delay");

    chk_edge_delay_due: assert property (@(posedge sys_clk) disable iff (rst)
        s_edge_due |=> edge_out && edge_busy)
        else $error("edge timer output late");

    chk_edge_pulse_hold: assert property (@(posedge sys_clk) disable iff (rst)
        s_pulse_hold |=> edge_out)
        else $error("edge pulse ended early");

    chk_edge_pulse_end: assert property (@(posedge sys_clk) disable iff (rst)
        s_pulse_last |=> !edge_out && !edge_busy)
        else $error("edge pulse ran too long");

    chk_edge_zero_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        s_zero_pulse_end |=> !edge_out)
        else $error("zero pulse not one interval");

    chk_edge_lockout: assert property (@(posedge sys_clk) disable iff (rst)
        edge_busy && !edge_out && $rose(edge_in) |=> edge_state_reg != EDGE_IDLE || edge_out)
        else $error("edge timer restarted while busy");

    chk_latch_prio: assert property (@(posedge sys_clk) disable iff (rst)
        tick && latch_in.set && latch_in.clr |=> !latch_out)
        else $error("latch reset priority lost");

    chk_latch_set: assert property (@(posedge sys_clk) disable iff (rst)
        tick && latch_in.set && !latch_in.clr |=> latch_out)
        else $error("latch did not set");

    chk_latch_clear: assert property (@(posedge sys_clk) disable iff (rst)
        tick && latch_in.clr |=> !latch_out)
        else $error("latch did not clear");

    chk_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
        tick && latch_out && !latch_in.clr |=> latch_out)
        else $error("latch dropped without reset");

    chk_fall_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        tick && fall_prev_reg && !fall_in |=> fall_out)
        else $error("falling edge missed");

    chk_fall_single: assert property (@(posedge sys_clk) disable iff (rst)
        tick && fall_out && !(fall_prev_reg && !fall_in) |=> !fall_out)
        else $error("falling edge pulse too long");

endmodule

// ---- bench/rlp_primitives_tb.sv ----
// Self-checking testbench for the relay logic primitives
`timescale 1ns/1ns

module rlp_primitives_tb;
    typedef struct packed {
        logic c, g, d, e, b, l, f;
    } rlp_exp_t;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic tick = 1'b0;
    logic [15:0] cmp_a = 16'h0000;
    logic [15:0] cmp_b = 16'h0000;
    rlp_pkg::rlp_gate_cfg_t gate_cfg = '0;
    logic gate_a = 1'b0;
    logic gate_b = 1'b0;
    rlp_pkg::rlp_delay_cfg_t dly_cfg = '0;
    logic dly_in = 1'b0;
    rlp_pkg::rlp_edge_cfg_t edge_cfg = '0;
    logic edge_in = 1'b0;
    rlp_pkg::rlp_latch_in_t latch_in = '0;
    logic fall_in = 1'b0;
    logic cmp_out, gate_out, dly_out, edge_out, edge_busy, latch_out, fall_out;
    int bad_count = 0;
    int comparisons = 0;
    rlp_exp_t exp_q[$];
    rlp_exp_t m = '0;
    int hc = 0;
    int lc = 0;
    int ek = 0;
    logic erun = 1'b0;
    logic eprev = 1'b0;
    logic fprev = 1'b0;

    rlp_primitives uut (
        .sys_clk, .rst, .tick, .cmp_a, .cmp_b, .cmp_out, .gate_cfg, .gate_a, .gate_b,
        .gate_out, .dly_cfg, .dly_in, .dly_out, .edge_cfg, .edge_in, .edge_out, .edge_busy,
        .latch_in, .latch_out, .fall_in, .fall_out
    );

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(logic [6:0] seen, logic [6:0] want, string what);
        comparisons++;
        if (seen !== want) begin
            $display("ERROR at %0t: %s saw %b expected %b", $time, what, seen, want);
            bad_count++;
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic gate_f(rlp_pkg::rlp_gate_cfg_t c, logic a, logic b);
        logic x, y, r;
        x = a ^ c.inv_a;
        y = b ^ c.inv_b;
        case (c.mode)
            rlp_pkg::GATE_OR: r = x | y;
            rlp_pkg::GATE_XOR: r = x ^ y;
            rlp_pkg::GATE_NOR: r = ~(x | y);
            rlp_pkg::GATE_AND: r = x & y;
            rlp_pkg::GATE_AND_INV: r = x & ~y;
            rlp_pkg::GATE_NAND: r = ~(x & y);
            default: r = 1'b0;
        endcase
        return r ^ c.inv_out;
    endfunction

    // Drive one interval of random inputs and note what the next edge must show
    task automatic step;
        int em;
        tick = ($urandom_range(3) != 0);
        cmp_a = 16'($urandom & 32'h8007);
        cmp_b = 16'($urandom & 32'h8007);
        gate_cfg = rlp_pkg::rlp_gate_cfg_t'(6'($urandom));
        {gate_a, gate_b, fall_in} = 3'($urandom);
        latch_in = rlp_pkg::rlp_latch_in_t'(2'($urandom));
        // A rise during dropout is driven too: it must restart the dropout count
        if ($urandom_range(5) == 0) dly_in = ~dly_in;
        if (!dly_in && !m.d && $urandom_range(7) == 0) begin
            dly_cfg = {16'($urandom_range(4)), 16'($urandom_range(4))};
        end
        if ($urandom_range(3) == 0) edge_in = ~edge_in;
        if (!erun && $urandom_range(7) == 0) begin
            edge_cfg = {16'($urandom_range(3)), 16'($urandom_range(3))};
        end
        if (tick) begin
            m.c = cmp_a > cmp_b;
            m.g = gate_f(gate_cfg, gate_a, gate_b);
            if (dly_in) begin
                hc++;
                lc = 0;
                m.d = m.d | (hc >= int'(dly_cfg.pickup));
            end else begin
                hc = 0;
                lc++;
                m.d = m.d & (lc <= int'(dly_cfg.dropout));
            end
            if (!erun && edge_in && !eprev) begin
                erun = 1'b1;
                ek = 0;
            end else if (erun) begin
                ek++;
            end
            eprev = edge_in;
            em = (edge_cfg.pulse == 16'h0000) ? 1 : int'(edge_cfg.pulse);
            m.e = erun && ek >= int'(edge_cfg.delay) && ek < int'(edge_cfg.delay) + em;
            if (erun && ek >= int'(edge_cfg.delay) + em) erun = 1'b0;
            m.b = erun;
            m.l = latch_in.clr ? 1'b0 : (latch_in.set | m.l);
            m.f = fprev & ~fall_in;
            fprev = fall_in;
        end
        exp_q.push_back(m);
    endtask

    initial begin
        rlp_exp_t e;
        forever begin
            @(posedge sys_clk);
            #1;
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                check({6'h00, cmp_out}, {6'h00, e.c}, "compare");
                check({6'h00, gate_out}, {6'h00, e.g}, "gate");
                check({6'h00, dly_out}, {6'h00, e.d}, "delay");
                check({6'h00, edge_out}, {6'h00, e.e}, "edge");
                check({6'h00, edge_busy}, {6'h00, e.b}, "busy");
                check({6'h00, latch_out}, {6'h00, e.l}, "latch");
                check({6'h00, fall_out}, {6'h00, e.f}, "fall");
            end
        end
    end

    initial begin
        void'($urandom(32'h92fc));
        repeat (8) @(negedge sys_clk);
        check({cmp_out, gate_out, dly_out, edge_out, edge_busy, latch_out, fall_out}, 7'h00,
              "reset");
        rst = 1'b0;
        repeat (3000) begin
            step();
            @(negedge sys_clk);
        end
        tick = 1'b0;
        repeat (3) @(negedge sys_clk);
        conclude();
    end

    // Expected run is about 24 us; give it ample margin before cutting it short
    initial begin
        #40000;
        $display("ERROR at %0t: run did not finish", $time);
        bad_count++;
        conclude();
    end
endmodule
